/* core/fetx_encoder.sv */
// fetx_encoder: nibble to code-group encoder, scrambler, NRZI and MLT-3 driver streams
//
// How it works
// (RULE1) every accepted nibble becomes one code-group
// (RULE2) fixed 4B to 5B data mapping
// (RULE3) frame start sends J then K
// (RULE4) enable drop sends T then R; a drop during K sends K then R
// (RULE5) idles repeat until the next frame
// (RULE6) halt code-group is 00100
// (RULE7) error during frame sends halt, delimiters kept
// (RULE8) injection select at bits 8:7 of 16h
// (RULE9) fault pattern or two square waves
// (RULE10) injected patterns carry no delimiters
// (RULE11) patterns scrambled unless bit 12 or the fiber strap bypasses
// (RULE12) fiber strap moves output to fiber pin
// (RULE13) no injection while in symbol mode
// (RULE14) eleven-bit closed-loop LFSR xored with stream
// (RULE15) seed derived from strapped PHY address
// (RULE16) fiber strap bypasses scrambler, else software
// (RULE17) symbol mode passes raw 5-bit symbols
// (RULE18) NRZI encoding always applied
// (RULE19) ones alternate between two drive streams
// (RULE20) twisted-pair output is always MLT-3; in fiber mode the code holds both pair streams low
// (RULE21) one code-group per nibble on line
// (RULE22) idle, start, data, end, error sequencing
// (RULE23) one nibble per transmit clock edge
// (RULE24) reset gives idles and seeded scrambler
// (RULE25) leftmost code bit sent first
`timescale 1ns/100ps
`default_nettype none

module fetx_fifo #(
    parameter int WIDTH = 5,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_in,
    input  wire logic             srst_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic      [WIDTH-1:0] out_data_out
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic             push;
    logic             pop;

    assign in_ready_out  = (count_reg != (AW + 1)'(DEPTH));
    assign out_valid_out = (count_reg != '0);
    assign out_data_out  = mem_reg[rd_ptr_reg];
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule

module fetx_encoder
    import fetx_pkg::*;
#(
    parameter int BIT_CYCLES = BIT_CYCLES_DEFAULT,
    parameter int FIFO_DEPTH = FIFO_DEPTH_DEFAULT
) (
    input  wire logic        clk_in,
    input  wire logic        srst_in,
    input  wire logic        tx_clk_in,
    input  wire logic [3:0]  tx_data_in,
    input  wire logic        tx_en_in,
    input  wire logic        tx_er_in,
    input  wire logic        fiber_mode_strap_in,
    input  wire logic [4:0]  phy_address_straps_in,
    input  wire logic        reg_wr_in,
    input  wire logic [4:0]  reg_addr_in,
    input  wire logic [15:0] reg_wdata_in,
    output logic      [15:0] reg_rdata_out,
    output logic             twisted_pair_tx_pos_out,
    output logic             twisted_pair_tx_neg_out,
    output logic             fiber_aux_tx_out
);
    typedef enum {ST_IDLE, ST_K, ST_DATA, ST_R} fetx_state_e;

    function automatic logic [4:0] fetx_enc4b5b(input logic [3:0] nib);
        logic [4:0] code;
        code = CODE_IDLE;
        unique case (nib)
            4'h0: code = 5'h1e;
            4'h1: code = 5'h09;
            4'h2: code = 5'h14;
            4'h3: code = 5'h15;
            4'h4: code = 5'h0a;
            4'h5: code = 5'h0b;
            4'h6: code = 5'h0e;
            4'h7: code = 5'h0f;
            4'h8: code = 5'h12;
            4'h9: code = 5'h13;
            4'ha: code = 5'h16;
            4'hb: code = 5'h17;
            4'hc: code = 5'h1a;
            4'hd: code = 5'h1b;
            4'he: code = 5'h1c;
            4'hf: code = 5'h1d;
        endcase
        return code; // [RULE2]
    endfunction

    // pin synchronisers
    logic [2:0]  tx_clk_sync_reg;
    logic [3:0]  data_meta_reg;
    logic [3:0]  data_sync_reg;
    logic [1:0]  ctl_meta_reg;
    logic [1:0]  ctl_sync_reg;
    logic [5:0]  strap_meta_reg;
    logic [5:0]  strap_sync_reg;
    logic        tx_edge;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            tx_clk_sync_reg <= '0;
            data_meta_reg   <= '0;
            data_sync_reg   <= '0;
            ctl_meta_reg    <= '0;
            ctl_sync_reg    <= '0;
            strap_meta_reg  <= '0;
            strap_sync_reg  <= '0;
        end else begin
            tx_clk_sync_reg <= {tx_clk_sync_reg[1:0], tx_clk_in};
            data_meta_reg   <= tx_data_in;
            data_sync_reg   <= data_meta_reg;
            ctl_meta_reg    <= {tx_en_in, tx_er_in};
            ctl_sync_reg    <= ctl_meta_reg;
            strap_meta_reg  <= {fiber_mode_strap_in, phy_address_straps_in};
            strap_sync_reg  <= strap_meta_reg;
        end
    end

    assign tx_edge = tx_clk_sync_reg[1] && !tx_clk_sync_reg[2]; // [RULE23]

    // strap capture on the third cycle after reset release
    logic [1:0]  strap_wait_reg;
    logic        strap_done_reg;
    logic        strap_load;
    logic        fiber_mode_reg;
    logic [4:0]  phy_address_value_reg;

    assign strap_load = (strap_wait_reg == 2'h2) && !strap_done_reg;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            strap_wait_reg        <= '0;
            strap_done_reg        <= 1'b0;
            fiber_mode_reg        <= 1'b0;
            phy_address_value_reg <= '0;
        end else begin
            if (strap_wait_reg != 2'h2) begin
                strap_wait_reg <= strap_wait_reg + 2'h1;
            end
            if (strap_load) begin
                strap_done_reg        <= 1'b1;
                fiber_mode_reg        <= strap_sync_reg[5];
                phy_address_value_reg <= strap_sync_reg[4:0]; // [RULE15]
            end
        end
    end

    // registers
    logic [15:0] pcs_configuration_reg;
    logic [15:0] loopback_and_bypass_control_reg;
    logic        overflow_reg;
    logic        overflow_set;
    logic [1:0]  inject_sel;
    logic        symbol_mode;
    logic        scr_bypass;
    logic        inject_on;
    fetx_state_e state_reg;

    assign inject_sel  = pcs_configuration_reg[INJECT_SEL_MSB:INJECT_SEL_LSB]; // [RULE8]
    assign symbol_mode = loopback_and_bypass_control_reg[SYMBOL_MODE_BIT];
    assign scr_bypass  = fiber_mode_reg
                         || loopback_and_bypass_control_reg[SCRAMBLER_BYPASS_BIT]; // [RULE16]
    assign inject_on   = (inject_sel != INJECT_OFF) && !symbol_mode; // [RULE13]

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            pcs_configuration_reg           <= PCS_CONFIGURATION_RST;
            loopback_and_bypass_control_reg <= LOOPBACK_BYPASS_RST;
        end else if (reg_wr_in) begin
            if (reg_addr_in == PCS_CONFIGURATION_ADDR) begin
                pcs_configuration_reg <= reg_wdata_in;
            end
            if (reg_addr_in == LOOPBACK_BYPASS_ADDR) begin
                loopback_and_bypass_control_reg <= reg_wdata_in;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            overflow_reg <= 1'b0;
        end else if (overflow_set) begin
            overflow_reg <= 1'b1;
        end else if (reg_wr_in && reg_addr_in == PCS_CONFIGURATION_ADDR
                     && reg_wdata_in[OVERFLOW_BIT]) begin
            overflow_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            reg_rdata_out <= '0;
        end else begin
            unique case (reg_addr_in)
                PCS_CONFIGURATION_ADDR: begin
                    reg_rdata_out <= {pcs_configuration_reg[15:2],
                                      state_reg != ST_IDLE, overflow_reg};
                end
                LOOPBACK_BYPASS_ADDR: begin
                    reg_rdata_out <= loopback_and_bypass_control_reg;
                end
                default: begin
                    reg_rdata_out <= '0;
                end
            endcase
        end
    end

    // code-group sequencer, one code per transmit clock edge
    logic [4:0]  code_next;
    fetx_state_e state_next;
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic        fifo_pop;
    logic [4:0]  fifo_out_data;

    always_comb begin
        code_next  = CODE_IDLE;
        state_next = state_reg;
        if (symbol_mode) begin
            code_next  = {ctl_sync_reg[0], data_sync_reg}; // [RULE17]
            state_next = ST_IDLE;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (ctl_sync_reg[1]) begin
                        code_next  = CODE_J; // [RULE3]
                        state_next = ST_K;
                    end else begin
                        code_next = CODE_IDLE; // [RULE5]
                    end
                end
                ST_K: begin
                    code_next  = CODE_K; // [RULE3]
                    state_next = ctl_sync_reg[1] ? ST_DATA : ST_R;
                    if (!ctl_sync_reg[1]) begin
                        code_next = CODE_K;
                    end
                end
                ST_DATA: begin
                    if (!ctl_sync_reg[1]) begin
                        code_next  = CODE_T; // [RULE4]
                        state_next = ST_R;
                    end else if (ctl_sync_reg[0]) begin
                        code_next = CODE_HALT; // [RULE6] [RULE7]
                    end else begin
                        code_next = fetx_enc4b5b(data_sync_reg); // [RULE1]
                    end
                end
                ST_R: begin
                    code_next  = CODE_R; // [RULE4]
                    state_next = ST_IDLE; // [RULE22]
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state_reg <= ST_IDLE; // [RULE24]
        end else if (tx_edge) begin
            state_reg <= state_next;
        end
    end

    assign overflow_set = tx_edge && !fifo_in_ready;

    fetx_fifo #(
        .WIDTH (SYMBOL_BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_in        (clk_in),
        .srst_in       (srst_in),
        .in_valid_in   (tx_edge),
        .in_ready_out  (fifo_in_ready),
        .in_data_in    (code_next),
        .out_valid_out (fifo_out_valid),
        .out_ready_in  (fifo_pop),
        .out_data_out  (fifo_out_data)
    );

    // serializer, pattern source, scrambler
    localparam int BCW = $clog2(BIT_CYCLES + 1);
    logic [BCW-1:0] bit_timer_reg;
    logic           bit_tick;
    logic [2:0]     bit_idx_reg;
    logic [4:0]     shift_reg;
    logic [7:0]     pat_cnt_reg;
    logic [7:0]     pat_len;
    logic           pat_bit;
    logic [SCRAMBLER_LEN-1:0] lfsr_reg;
    logic           lfsr_fb;
    logic           nrz_bit;
    logic           line_bit;

    assign bit_tick = (bit_timer_reg == BCW'(BIT_CYCLES - 1));
    assign fifo_pop = bit_tick && (bit_idx_reg == 3'h4) && fifo_out_valid; // [RULE21]

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            bit_timer_reg <= '0;
            bit_idx_reg   <= 3'h4;
            shift_reg     <= CODE_IDLE;
        end else begin
            bit_timer_reg <= bit_tick ? '0 : bit_timer_reg + 1'b1;
            if (bit_tick) begin
                if (bit_idx_reg == 3'h4) begin
                    bit_idx_reg <= '0;
                    shift_reg   <= fifo_out_valid ? fifo_out_data : CODE_IDLE;
                end else begin
                    bit_idx_reg <= bit_idx_reg + 3'h1;
                    shift_reg   <= {shift_reg[3:0], 1'b0}; // [RULE25]
                end
            end
        end
    end

    always_comb begin
        pat_len = 8'(FAR_END_FAULT_BITS);
        pat_bit = (pat_cnt_reg != 8'(FAR_END_FAULT_ONES));
        unique case (inject_sel)
            INJECT_SQUARE_SLOW: begin
                pat_len = 8'(2 * SQUARE_SLOW_HALF_BITS);
                pat_bit = (pat_cnt_reg < 8'(SQUARE_SLOW_HALF_BITS));
            end
            INJECT_SQUARE_FAST: begin
                pat_len = 8'(2 * SQUARE_FAST_HALF_BITS);
                pat_bit = (pat_cnt_reg < 8'(SQUARE_FAST_HALF_BITS));
            end
            default: begin
                pat_len = 8'(FAR_END_FAULT_BITS);
                pat_bit = (pat_cnt_reg != 8'(FAR_END_FAULT_ONES));
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (srst_in || !inject_on) begin
            pat_cnt_reg <= '0;
        end else if (bit_tick) begin
            pat_cnt_reg <= (pat_cnt_reg >= pat_len - 8'h1) ? '0 : pat_cnt_reg + 8'h1; // [RULE9]
        end
    end

    // injected bits replace the code stream, no delimiters
    assign nrz_bit  = inject_on ? pat_bit : shift_reg[4]; // [RULE10]
    assign lfsr_fb  = lfsr_reg[SCRAMBLER_LEN-1] ^ lfsr_reg[SCRAMBLER_TAP];
    assign line_bit = scr_bypass ? nrz_bit : (nrz_bit ^ lfsr_fb); // [RULE11] [RULE14]

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            lfsr_reg <= '1;
        end else if (strap_load) begin
            lfsr_reg <= {strap_sync_reg[4:0], ~strap_sync_reg[4:0], 1'b1}; // [RULE15] [RULE24]
        end else if (bit_tick) begin
            lfsr_reg <= {lfsr_reg[SCRAMBLER_LEN-2:0], lfsr_fb}; // [RULE14]
        end
    end

    // NRZI and MLT-3 drive streams
    logic       nrzi_reg;
    logic [1:0] mlt_phase_reg;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            nrzi_reg                <= 1'b0;
            mlt_phase_reg           <= '0;
            twisted_pair_tx_pos_out <= 1'b0;
            twisted_pair_tx_neg_out <= 1'b0;
            fiber_aux_tx_out        <= 1'b0;
        end else if (bit_tick) begin
            nrzi_reg <= nrzi_reg ^ line_bit; // [RULE18]
            if (line_bit) begin
                mlt_phase_reg <= mlt_phase_reg + 2'h1;
            end
            if (fiber_mode_reg) begin
                twisted_pair_tx_pos_out <= 1'b0; // [RULE12]
                twisted_pair_tx_neg_out <= 1'b0;
                fiber_aux_tx_out        <= nrzi_reg ^ line_bit; // [RULE12]
            end else begin
                twisted_pair_tx_pos_out <= (mlt_phase_reg + 2'(line_bit)) == 2'h1; // [RULE19]
                twisted_pair_tx_neg_out <= (mlt_phase_reg + 2'(line_bit)) == 2'h3; // [RULE20]
                fiber_aux_tx_out        <= 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

/* core/fetx_pkg.sv */
// fetx_pkg: constants for the 100 Mb/s transmit coding path
package fetx_pkg;
    // register indices on the register port
    localparam logic [4:0]  PCS_CONFIGURATION_ADDR = 5'h16;
    localparam logic [4:0]  LOOPBACK_BYPASS_ADDR   = 5'h17;
    // field positions
    localparam int          INJECT_SEL_LSB         = 7;
    localparam int          INJECT_SEL_MSB         = 8;
    localparam int          OVERFLOW_BIT           = 0;
    localparam int          IN_FRAME_BIT           = 1;
    localparam int          SCRAMBLER_BYPASS_BIT   = 12;
    localparam int          SYMBOL_MODE_BIT        = 13;
    // reset values
    localparam logic [15:0] PCS_CONFIGURATION_RST  = 16'h0000;
    localparam logic [15:0] LOOPBACK_BYPASS_RST    = 16'h0000;
    // injection select codes
    localparam logic [1:0]  INJECT_OFF             = 2'h0;
    localparam logic [1:0]  INJECT_FAR_END_FAULT   = 2'h1;
    localparam logic [1:0]  INJECT_SQUARE_SLOW     = 2'h2;
    localparam logic [1:0]  INJECT_SQUARE_FAST     = 2'h3;
    // control code-groups, leftmost bit first on the line
    localparam logic [4:0]  CODE_IDLE              = 5'h1f;
    localparam logic [4:0]  CODE_J                 = 5'h18;
    localparam logic [4:0]  CODE_K                 = 5'h11;
    localparam logic [4:0]  CODE_T                 = 5'h0d;
    localparam logic [4:0]  CODE_R                 = 5'h07;
    localparam logic [4:0]  CODE_HALT              = 5'h04;
    // line timing
    localparam int          CLK_PERIOD_PS          = 25000;
    localparam int          LINE_BIT_PS            = 8000;
    localparam int          SQUARE_SLOW_PERIOD_PS  = 1280000;
    localparam int          SQUARE_FAST_PERIOD_PS  = 160000;
    localparam int          SQUARE_SLOW_HALF_BITS  = SQUARE_SLOW_PERIOD_PS / (2 * LINE_BIT_PS);
    localparam int          SQUARE_FAST_HALF_BITS  = SQUARE_FAST_PERIOD_PS / (2 * LINE_BIT_PS);
    localparam int          FAR_END_FAULT_ONES     = 84;
    localparam int          FAR_END_FAULT_BITS     = FAR_END_FAULT_ONES + 1;
    localparam int          BIT_CYCLES_DEFAULT     = 8;
    localparam int          SYMBOL_BITS            = 5;
    localparam int          FIFO_DEPTH_DEFAULT     = 8;
    // scrambler
    localparam int          SCRAMBLER_LEN          = 11;
    localparam int          SCRAMBLER_TAP          = 8;
endpackage

/* sim/fetx_encoder_properties.sv */
// fetx_encoder_properties: port-level checks for the transmit coding path
`timescale 1ns/100ps
`default_nettype none
module fetx_encoder_properties
    import fetx_pkg::*;
(
    input wire logic        clk_in,
    input wire logic        srst_in,
    input wire logic        fiber_mode_strap_in,
    input wire logic        reg_wr_in,
    input wire logic [4:0]  reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic [15:0] reg_rdata_out,
    input wire logic        twisted_pair_tx_pos_out,
    input wire logic        twisted_pair_tx_neg_out,
    input wire logic        fiber_aux_tx_out
);
    logic [3:0] settle_cnt;
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            settle_cnt <= 4'h0;
        end else if (settle_cnt != 4'hf) begin
            settle_cnt <= settle_cnt + 4'h1;
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);
    sequence s_wr_lb;
        reg_wr_in && reg_addr_in == LOOPBACK_BYPASS_ADDR ##1 reg_addr_in == LOOPBACK_BYPASS_ADDR;
    endsequence
    AST_WR_READBACK: assert property (
        s_wr_lb |=> reg_rdata_out == $past(reg_wdata_in, 2))
        else $error("readback mismatch");
    AST_UNMAPPED_ZERO: assert property (
        reg_addr_in != PCS_CONFIGURATION_ADDR && reg_addr_in != LOOPBACK_BYPASS_ADDR
        |=> reg_rdata_out == 16'h0000)
        else $error("unmapped read not zero");
    AST_RESET_QUIET: assert property (disable iff (1'b0)
        srst_in |=> reg_rdata_out == 16'h0000
        && !twisted_pair_tx_pos_out && !twisted_pair_tx_neg_out && !fiber_aux_tx_out)
        else $error("outputs active in reset");
    AST_MLT3_EXCL: assert property (
        !(twisted_pair_tx_pos_out && twisted_pair_tx_neg_out))
        else $error("both drive streams high");
    AST_MLT3_STEP: assert property (
        $rose(twisted_pair_tx_neg_out) |-> !$past(twisted_pair_tx_pos_out))
        else $error("stream skipped zero");
    AST_FIBER_TP_OFF: assert property (
        settle_cnt == 4'hf && fiber_mode_strap_in
        |-> !twisted_pair_tx_pos_out && !twisted_pair_tx_neg_out)
        else $error("pair on in fiber mode");
    AST_TP_FIBER_OFF: assert property (
        settle_cnt == 4'hf && !fiber_mode_strap_in |-> !fiber_aux_tx_out)
        else $error("fiber on in pair mode");
    AST_FIBER_BIT_HOLD: assert property (
        $changed(fiber_aux_tx_out) |=> $stable(fiber_aux_tx_out) [*7])
        else $error("fiber bit short");
    AST_TP_BIT_HOLD: assert property (
        $changed({twisted_pair_tx_pos_out, twisted_pair_tx_neg_out})
        |=> $stable({twisted_pair_tx_pos_out, twisted_pair_tx_neg_out}) [*7])
        else $error("pair bit short");
endmodule
bind fetx_encoder fetx_encoder_properties u_props (
    .clk_in(clk_in), .srst_in(srst_in), .fiber_mode_strap_in(fiber_mode_strap_in),
    .reg_wr_in(reg_wr_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .twisted_pair_tx_pos_out(twisted_pair_tx_pos_out),
    .twisted_pair_tx_neg_out(twisted_pair_tx_neg_out), .fiber_aux_tx_out(fiber_aux_tx_out)
);
`default_nettype wire

/* sim/fetx_encoder_tb.sv */
// fetx_encoder_tb: bench for the transmit coding path
`timescale 1ns/100ps
`default_nettype none
module fetx_encoder_tb
    import fetx_pkg::*;
();
    logic        clk_in = 1'b0;
    logic        srst_in = 1'b1;
    logic        fib_strap = 1'b1;
    logic [4:0]  phy_adr = 5'h0a;
    logic        reg_wr = 1'b0;
    logic [4:0]  reg_addr = 5'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata;
    logic        tp_pos;
    logic        tp_neg;
    logic        fib_tx;
    logic        tx_clk;
    logic        tx_en;
    logic        tx_er;
    logic [3:0]  tx_data;
    logic [1:0]  line_v;
    logic        bits[$];
    int          errors = 0;
    int          check_count = 0;
    localparam logic [4:0] ENC [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e,
        5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
    always #12.5 clk_in = ~clk_in;
    assign line_v = fib_strap ? {1'b0, fib_tx} : {tp_pos, tp_neg};
    fetx_encoder dut (
        .clk_in(clk_in), .srst_in(srst_in), .tx_clk_in(tx_clk), .tx_data_in(tx_data),
        .tx_en_in(tx_en), .tx_er_in(tx_er), .fiber_mode_strap_in(fib_strap),
        .phy_address_straps_in(phy_adr), .reg_wr_in(reg_wr), .reg_addr_in(reg_addr),
        .reg_wdata_in(reg_wdata), .reg_rdata_out(reg_rdata), .twisted_pair_tx_pos_out(tp_pos),
        .twisted_pair_tx_neg_out(tp_neg), .fiber_aux_tx_out(fib_tx));
    fetx_mii_mac mac (.clk_in(clk_in), .tx_clk_out(tx_clk), .tx_data_out(tx_data),
        .tx_en_out(tx_en),
        .tx_er_out(tx_er));
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic do_reset(input logic f, input logic [4:0] a);
        @(posedge clk_in);
        srst_in <= 1'b1;
        fib_strap <= f;
        phy_adr <= a;
        repeat (20) @(posedge clk_in);
        srst_in <= 1'b0;
        repeat (8) @(posedge clk_in);
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_in);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_in);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
        @(posedge clk_in);
        reg_addr <= a;
        repeat (2) @(posedge clk_in);
        chk("register", e, reg_rdata);
    endtask
    // line bits recovered from level changes, sampled mid-bit
    task automatic grab(input int n);
        logic [1:0] prev;
        int w;
        bits = {};
        w = 0;
        prev = line_v;
        while (line_v === prev && w < 400) begin
            @(posedge clk_in);
            w++;
        end
        repeat (4) @(posedge clk_in);
        prev = line_v;
        repeat (n) begin
            repeat (8) @(posedge clk_in);
            bits.push_back(line_v !== prev);
            prev = line_v;
        end
    endtask
    function automatic logic [15:0] ones(input int s, input int n);
        logic [15:0] c;
        c = 16'h0000;
        for (int i = s; i < s + n; i++) c = c + 16'(bits[i]);
        return c;
    endfunction
    function automatic logic [4:0] get5(input int s);
        return {bits[s], bits[s+1], bits[s+2], bits[s+3], bits[s+4]};
    endfunction
    task automatic reg_test;
        rd_chk(PCS_CONFIGURATION_ADDR, PCS_CONFIGURATION_RST);
        rd_chk(LOOPBACK_BYPASS_ADDR, LOOPBACK_BYPASS_RST);
        wr(5'h03, 16'hffff);
        rd_chk(5'h03, 16'h0000);
        wr(PCS_CONFIGURATION_ADDR, 16'h7e7c);
        rd_chk(PCS_CONFIGURATION_ADDR, 16'h7e7c);
        wr(PCS_CONFIGURATION_ADDR, 16'h0000);
        wr(LOOPBACK_BYPASS_ADDR, 16'h1000);
        rd_chk(LOOPBACK_BYPASS_ADDR, 16'h1000);
        wr(LOOPBACK_BYPASS_ADDR, 16'h0000);
        $display("register test done");
    endtask
    task automatic frame_test(input int f);
        logic [4:0] q[$];
        logic [4:0] e[$];
        int z;
        q = '{5'h05, 5'h05};
        e = '{CODE_J, CODE_K};
        for (int i = 0; i < 4; i++) begin
            q.push_back({1'b0, 4'(4 * f + i)});
            e.push_back(ENC[4 * f + i]);
        end
        if (f == 3) begin
            q.push_back(5'h10);
            e.push_back(CODE_HALT);
        end
        e.push_back(CODE_T);
        e.push_back(CODE_R);
        e.push_back(CODE_IDLE);
        fork
            mac.send(q);
            grab(75);
        join
        z = 0;
        while (z < bits.size() && bits[z]) z++;
        foreach (e[k]) chk("code", 16'(e[k]), 16'(get5(z - 2 + 5 * k)));
        $display("frame test done");
    endtask
    task automatic inject_test;
        int tab[5][4] = '{'{0, 1, 85, 84}, '{0, 2, 160, 80}, '{0, 3, 40, 20},
            '{1, 3, 40, 40}, '{0, 0, 40, 40}};
        for (int i = 0; i < 5; i++) begin
            wr(LOOPBACK_BYPASS_ADDR, {2'b00, tab[i][0][0], 13'h0000});
            wr(PCS_CONFIGURATION_ADDR, {7'h00, 2'(tab[i][1]), 7'h00});
            grab(100 + tab[i][2]);
            chk("pattern ones", 16'(tab[i][3]), ones(100, tab[i][2]));
        end
        $display("injection test done");
    endtask
    task automatic overflow_test;
        logic [4:0] q[$];
        q = '{5'h05, 5'h05};
        repeat (16) q.push_back(5'h0a);
        mac.send(q);
        rd_chk(PCS_CONFIGURATION_ADDR, 16'h0001);
        wr(PCS_CONFIGURATION_ADDR, 16'h0001);
        rd_chk(PCS_CONFIGURATION_ADDR, 16'h0000);
        repeat (800) @(posedge clk_in);
        $display("overflow test done");
    endtask
    task automatic tp_test;
        do_reset(1'b0, 5'h13);
        grab(40);
        chk("scrambled idle", 16'h0000, 16'(ones(0, 40) == 16'd40));
        wr(LOOPBACK_BYPASS_ADDR, 16'h1000);
        frame_test(1);
        $display("twisted pair test done");
    endtask
    initial begin
        do_reset(1'b1, 5'h0a);
        reg_test();
        for (int f = 0; f < 4; f++) frame_test(f);
        inject_test();
        overflow_test();
        tp_test();
        close_out();
    end
    initial begin
        #2000000;
        errors++;
        close_out();
    end
endmodule
`default_nettype wire

/* sim/fetx_mii_mac.sv */
// fetx_mii_mac: upstream agent model on the nibble lines
`timescale 1ns/100ps
`default_nettype none
module fetx_mii_mac (
    input  wire logic  clk_in,
    output logic       tx_clk_out,
    output logic [3:0] tx_data_out,
    output logic       tx_en_out,
    output logic       tx_er_out
);
    initial begin
        tx_clk_out = 1'b0;
        tx_data_out = 4'h0;
        tx_en_out = 1'b0;
        tx_er_out = 1'b0;
    end
    // one link period per nibble, clock still between frames
    task automatic pulse;
        repeat (4) @(posedge clk_in);
        tx_clk_out <= 1'b1;
        repeat (4) @(posedge clk_in);
        tx_clk_out <= 1'b0;
    endtask
    // bit 4 is the error flag
    task automatic send(input logic [4:0] q[$]);
        foreach (q[i]) begin
            tx_en_out <= 1'b1;
            tx_er_out <= q[i][4];
            tx_data_out <= q[i][3:0];
            pulse();
        end
        repeat (3) begin
            tx_en_out <= 1'b0;
            tx_er_out <= 1'b0;
            tx_data_out <= ~tx_data_out;
            pulse();
        end
    endtask
endmodule
`default_nettype wire
